//--- design/dsc_coder.sv
// differential symbol coder: buffers raw symbols, codes them and emits phase steps
`timescale 1ns/1ps
`include "dsc_map.svh"
module dsc_coder (
  input wire logic clock,
  input wire logic rst,
  input wire logic codeEnable,
  input wire dsc_pkg::dsc_coding_type codingSel,
  input wire logic threeBitSym,
  input wire logic symValid,
  output logic symReady,
  input wire logic [`DSC_SYM_W-1:0] symData,
  output logic outValid,
  input wire logic outReady,
  output logic [`DSC_SYM_W-1:0] outSym,
  output logic [`DSC_PHASE_W-1:0] outStep,
  output logic [`DSC_PHASE_W-1:0] outPhase
);

  // symbols pass a 32-word FIFO, then one coding stage, then a one-word output slot;
  // a symbol shows on the outputs one edge after it enters the FIFO at best;
  // every coding family is worked out side by side and one result is picked per symbol;
  // with coding on the recursion memory only moves on a take, so downstream stalls never skip a symbol;
  // coding off holds the FIFO and zeroes the recursion, leaving a full slot untouched;
  // a mode change with coding on keeps the memory, so clear it by dropping codeEnable

  // ----------------------------------------------------------------------------
  // input buffering
  // ----------------------------------------------------------------------------
  dsc_stream_if #(.WIDTH(`DSC_SYM_W)) inStream ();
  dsc_stream_if #(.WIDTH(`DSC_SYM_W)) codeStream ();

  // upstream pins onto the fill side
  assign inStream.valid = symValid;
  assign inStream.data = symData;
  assign symReady = inStream.ready;

  dsc_fifo #(
    .WIDTH(`DSC_SYM_W),
    .DEPTH(`DSC_FIFO_DEPTH)
  ) symFifo (
    .clock(clock),
    .rst(rst),
    .fillSide(inStream),
    .drainSide(codeStream)
  );

  // ----------------------------------------------------------------------------
  // coder state
  // ----------------------------------------------------------------------------
  logic [`DSC_SYM_W-1:0] prevSym_q;
  logic [`DSC_PHASE_W-1:0] phase_q;
  logic outValid_q;
  logic [`DSC_SYM_W-1:0] outSym_q;
  logic [`DSC_PHASE_W-1:0] outStep_q;
  logic [`DSC_PHASE_W-1:0] outPhase_q;
  logic take;
  logic [`DSC_SYM_W-1:0] rawSym;
  logic [`DSC_SYM_W-1:0] graySym;
  logic [`DSC_SYM_W-1:0] codedSym_d;
  logic [`DSC_PHASE_W-1:0] step_d;
  logic [`DSC_PHASE_W-1:0] phase_d;

  // per-family results, picked by the selection below
  logic useThree;
  logic [`DSC_SYM_W-1:0] pairSym;
  logic [`DSC_SYM_W-1:0] diffSym;
  logic [`DSC_PHASE_W-1:0] diffStep;
  logic [`DSC_PHASE_W-1:0] diffPhase;
  logic [`DSC_SYM_W-1:0] grayDiffSym;
  logic [`DSC_PHASE_W-1:0] grayDiffStep;
  logic [`DSC_PHASE_W-1:0] grayDiffPhase;
  logic [`DSC_PHASE_W-1:0] pi4OffStep;
  logic [`DSC_PHASE_W-1:0] pi4NadcStep;
  logic [`DSC_PHASE_W-1:0] pi4TftsStep;
  logic [`DSC_PHASE_W-1:0] pi4OffPhase;
  logic [`DSC_PHASE_W-1:0] pi4NadcPhase;
  logic [`DSC_PHASE_W-1:0] pi4TftsPhase;
  logic [`DSC_PHASE_W-1:0] absPhase;
  logic [`DSC_PHASE_W-1:0] absStep;

  // a symbol is taken only while coding is on and the output slot is free or being accepted
  assign codeStream.ready = codeEnable && (!outValid_q || outReady);
  assign take = codeStream.valid && codeStream.ready;

  // ----------------------------------------------------------------------------
  // symbol preparation
  // ----------------------------------------------------------------------------
  // two-bit symbols live in the low bits; the upper bit is forced to zero
  always_comb begin
    rawSym = codeStream.data;
    if (!threeBitSym) begin
      rawSym[2] = 1'b0;
    end
  end

  // binary to Gray conversion one bit at a time; the top bit passes straight through
  generate
    for (genvar gi = 0; gi < `DSC_SYM_W; gi++) begin : grayBit
      if (gi == `DSC_SYM_W - 1) begin : grayTop
        assign graySym[gi] = rawSym[gi];
      end else begin : grayLow
        assign graySym[gi] = rawSym[gi] ^ rawSym[gi+1];
      end
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------------------
  // the VDL table is the combined coder on three bits, whatever the width input says
  assign useThree = threeBitSym || (codingSel == dsc_pkg::CODE_VDL);

  // two-bit pi/4 modes report the symbol pair itself
  assign pairSym = {1'b0, rawSym[1:0]};

  // ----------------------------------------------------------------------------
  // plain differential coding
  // ----------------------------------------------------------------------------
  // modulo 8 on three bits, modulo 4 on two; a QPSK quarter turn is two 45 degree units
  always_comb begin
    if (threeBitSym) begin
      diffSym = `DSC_SYM_W'(rawSym + prevSym_q);
      diffStep = rawSym;
      diffPhase = `DSC_PHASE_W'(rawSym + prevSym_q);
    end else begin
      diffSym = {1'b0, 2'(rawSym[1:0] + prevSym_q[1:0])};
      diffStep = {rawSym[1:0], 1'b0};
      diffPhase = {2'(rawSym[1:0] + prevSym_q[1:0]), 1'b0};
    end
  end

  // ----------------------------------------------------------------------------
  // combined Gray and differential coding
  // ----------------------------------------------------------------------------
  // Gray first, recursion second; on three bits this gives the VDL step table
  always_comb begin
    if (useThree) begin
      grayDiffSym = `DSC_SYM_W'(graySym + prevSym_q);
      grayDiffStep = graySym;
      grayDiffPhase = `DSC_PHASE_W'(graySym + prevSym_q);
    end else begin
      grayDiffSym = {1'b0, 2'(graySym[1:0] + prevSym_q[1:0])};
      grayDiffStep = {graySym[1:0], 1'b0};
      grayDiffPhase = {2'(graySym[1:0] + prevSym_q[1:0]), 1'b0};
    end
  end

  // ----------------------------------------------------------------------------
  // pi/4 rotation tables
  // ----------------------------------------------------------------------------
  // rotation with coding off
  always_comb begin
    case (rawSym[1:0])
      2'h0: pi4OffStep = `DSC_STEP_P45;
      2'h1: pi4OffStep = `DSC_STEP_P135;
      2'h2: pi4OffStep = `DSC_STEP_M135;
      default: pi4OffStep = `DSC_STEP_M45;
    endcase
  end

  // rotation for the NADC-type selection
  always_comb begin
    case (rawSym[1:0])
      2'h0: pi4NadcStep = `DSC_STEP_P45;
      2'h1: pi4NadcStep = `DSC_STEP_P135;
      2'h2: pi4NadcStep = `DSC_STEP_M45;
      default: pi4NadcStep = `DSC_STEP_M135;
    endcase
  end

  // rotation for the TFTS selection
  always_comb begin
    case (rawSym[1:0])
      2'h0: pi4TftsStep = `DSC_STEP_M135;
      2'h1: pi4TftsStep = `DSC_STEP_P135;
      2'h2: pi4TftsStep = `DSC_STEP_M45;
      default: pi4TftsStep = `DSC_STEP_P45;
    endcase
  end

  // pi/4 modes rotate from the running phase, which wraps at a full turn
  assign pi4OffPhase = `DSC_PHASE_W'(phase_q + pi4OffStep);
  assign pi4NadcPhase = `DSC_PHASE_W'(phase_q + pi4NadcStep);
  assign pi4TftsPhase = `DSC_PHASE_W'(phase_q + pi4TftsStep);

  // ----------------------------------------------------------------------------
  // no coding
  // ----------------------------------------------------------------------------
  // absolute position; the step is the move from the last one
  assign absPhase = threeBitSym ? rawSym : {rawSym[1:0], 1'b0};
  assign absStep = `DSC_PHASE_W'(absPhase - phase_q);

  // ----------------------------------------------------------------------------
  // family selection
  // ----------------------------------------------------------------------------
  // one family result goes on to the slot; unknown codes fall back to no coding
  always_comb begin
    codedSym_d = rawSym;
    step_d = absStep;
    phase_d = absPhase;
    case (codingSel)
      dsc_pkg::CODE_DIFF: begin
        codedSym_d = diffSym;
        step_d = diffStep;
        phase_d = diffPhase;
      end
      dsc_pkg::CODE_DIFF_GRAY, dsc_pkg::CODE_VDL: begin
        codedSym_d = grayDiffSym;
        step_d = grayDiffStep;
        phase_d = grayDiffPhase;
      end
      dsc_pkg::CODE_PI4_OFF: begin
        codedSym_d = pairSym;
        step_d = pi4OffStep;
        phase_d = pi4OffPhase;
      end
      dsc_pkg::CODE_PI4_NADC: begin
        codedSym_d = pairSym;
        step_d = pi4NadcStep;
        phase_d = pi4NadcPhase;
      end
      dsc_pkg::CODE_PI4_TFTS: begin
        codedSym_d = pairSym;
        step_d = pi4TftsStep;
        phase_d = pi4TftsPhase;
      end
      default: begin
        // no coding: the symbol is placed as it stands
        codedSym_d = rawSym;
        step_d = absStep;
        phase_d = absPhase;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // recursion memory
  // ----------------------------------------------------------------------------
  // previous coded symbol; cleared while coding is off, so a re-enable starts from zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prevSym_q <= `DSC_SYM_RST;
    end else if (!codeEnable) begin
      prevSym_q <= `DSC_SYM_RST;
    end else if (take) begin
      prevSym_q <= codedSym_d;
    end
  end

  // running phase, cleared together with the symbol memory
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_q <= `DSC_PHASE_RST;
    end else if (!codeEnable) begin
      phase_q <= `DSC_PHASE_RST;
    end else if (take) begin
      phase_q <= phase_d;
    end
  end

  // ----------------------------------------------------------------------------
  // output slot
  // ----------------------------------------------------------------------------
  // slot full flag; a take refills the slot in the same cycle that it is accepted
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      outValid_q <= 1'b0;
    end else if (take) begin
      outValid_q <= 1'b1;
    end else if (outReady) begin
      outValid_q <= 1'b0;
    end
  end

  // coded symbol held until the downstream mapper accepts it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      outSym_q <= `DSC_SYM_RST;
    end else if (take) begin
      outSym_q <= codedSym_d;
    end
  end

  // phase step held with the symbol
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      outStep_q <= `DSC_STEP_0;
    end else if (take) begin
      outStep_q <= step_d;
    end
  end

  // absolute phase held with the symbol
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      outPhase_q <= `DSC_PHASE_RST;
    end else if (take) begin
      outPhase_q <= phase_d;
    end
  end

  // registered downstream outputs
  assign outValid = outValid_q;
  assign outSym = outSym_q;
  assign outStep = outStep_q;
  assign outPhase = outPhase_q;

endmodule : dsc_coder

//--- design/dsc_fifo.sv
// symbol FIFO with parameterised width and depth
`timescale 1ns/1ps
`include "dsc_map.svh"
module dsc_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic rst,
  dsc_stream_if.sink fillSide,
  dsc_stream_if.source drainSide
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  // ----------------------------------------------------------------------------
  // handshakes: full stalls the source, empty stalls the drain
  // ----------------------------------------------------------------------------
  assign fillSide.ready = (count_q != (AW+1)'(DEPTH));
  assign drainSide.valid = (count_q != '0);
  assign drainSide.data = mem[rdPtr_q];
  assign push = fillSide.valid && fillSide.ready;
  assign pop = drainSide.valid && drainSide.ready;

  // storage write
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr_q] <= fillSide.data;
    end
  end

  // pointers wrap at the depth
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : AW'(wrPtr_q + 1'b1);
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : AW'(rdPtr_q + 1'b1);
      end
    end
  end

  // fill level
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else if (push && !pop) begin
      count_q <= (AW+1)'(count_q + 1'b1);
    end else if (pop && !push) begin
      count_q <= (AW+1)'(count_q - 1'b1);
    end
  end

endmodule : dsc_fifo

//--- design/dsc_map.svh
// constants for the differential symbol coder: widths, depths and phase steps
`ifndef DSC_MAP_SVH
`define DSC_MAP_SVH

// ----------------------------------------------------------------------------
// widths and depths
// ----------------------------------------------------------------------------
`define DSC_SYM_W 3
`define DSC_PHASE_W 3
`define DSC_FIFO_DEPTH 32

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define DSC_SYM_RST 3'h0
`define DSC_PHASE_RST 3'h0

// ----------------------------------------------------------------------------
// phase steps in units of 45 degrees, modulo 360
// ----------------------------------------------------------------------------
`define DSC_STEP_0 3'h0
`define DSC_STEP_P45 3'h1
`define DSC_STEP_P90 3'h2
`define DSC_STEP_P135 3'h3
`define DSC_STEP_P180 3'h4
`define DSC_STEP_M135 3'h5
`define DSC_STEP_P270 3'h6
`define DSC_STEP_M45 3'h7

`endif

//--- design/dsc_pkg.sv
// types shared by the differential symbol coder modules
package dsc_pkg;

  // ----------------------------------------------------------------------------
  // coding selection
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CODE_NONE,
    CODE_DIFF,
    CODE_DIFF_GRAY,
    CODE_PI4_OFF,
    CODE_PI4_NADC,
    CODE_PI4_TFTS,
    CODE_VDL
  } dsc_coding_type;

endpackage : dsc_pkg

//--- design/dsc_stream_if.sv
// valid/ready stream carrier between the coder's own modules
`timescale 1ns/1ps
interface dsc_stream_if #(
  parameter int WIDTH = 3
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : dsc_stream_if

//--- dv/dsc_coder_monitor.sv
// concurrent checks on the coder's top-level ports
`timescale 1ns/1ps
module dsc_coder_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire logic codeEnable,
  input wire dsc_pkg::dsc_coding_type codingSel,
  input wire logic threeBitSym,
  input wire logic symValid,
  input wire logic symReady,
  input wire logic [2:0] symData,
  input wire logic outValid,
  input wire logic outReady,
  input wire logic [2:0] outSym,
  input wire logic [2:0] outStep,
  input wire logic [2:0] outPhase
);
  // ----------------------------------------
  // pi/4 step tables, 45 degree units
  // ----------------------------------------
  localparam logic [11:0] OFF_T = {3'h7, 3'h5, 3'h3, 3'h1};
  localparam logic [11:0] NADC_T = {3'h5, 3'h7, 3'h3, 3'h1};
  localparam logic [11:0] TFTS_T = {3'h1, 3'h7, 3'h3, 3'h5};
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // an accepted symbol followed at once by the next one
  sequence takenSeq; outValid && outReady && codeEnable; endsequence
  sequence nextSeq; outValid && codeEnable; endsequence
  AST_PHASE_ACC: assert property (takenSeq ##1 nextSeq |-> outPhase == 3'($past(outPhase) + outStep))
    else $error("phase did not advance by the step");
  AST_DIFF2: assert property (outValid && codingSel == dsc_pkg::CODE_DIFF && !threeBitSym |->
    !outSym[2] && !outStep[0] && outPhase == {outSym[1:0], 1'b0}) else $error("2-bit coding out of range");
  AST_PI4_OFF: assert property (outValid && codingSel == dsc_pkg::CODE_PI4_OFF |->
    outStep == OFF_T[3 * outSym[1:0] +: 3]) else $error("pi4 off step wrong");
  AST_PI4_NADC: assert property (outValid && codingSel == dsc_pkg::CODE_PI4_NADC |->
    outStep == NADC_T[3 * outSym[1:0] +: 3]) else $error("pi4 nadc step wrong");
  AST_PI4_TFTS: assert property (outValid && codingSel == dsc_pkg::CODE_PI4_TFTS |->
    outStep == TFTS_T[3 * outSym[1:0] +: 3]) else $error("pi4 tfts step wrong");
  AST_HOLD: assert property (outValid && !outReady |=> outValid && $stable(outSym) && $stable(outStep) &&
    $stable(outPhase)) else $error("output changed while stalled");
  AST_DISABLED: assert property (!codeEnable && !outValid |=> !outValid)
    else $error("symbol emitted while coding disabled");
  AST_RST_CLEAR: assert property ($fell(rst) |-> !outValid && outPhase == 3'h0 && symReady)
    else $error("state not cleared after reset");
endmodule : dsc_coder_monitor

//--- dv/dsc_coder_tb.sv
// self-checking testbench for the differential symbol coder
`timescale 1ns/1ps
module dsc_coder_tb;
  localparam logic [11:0] OFF_T = {3'h7, 3'h5, 3'h3, 3'h1};
  localparam logic [11:0] NADC_T = {3'h5, 3'h7, 3'h3, 3'h1};
  localparam logic [11:0] TFTS_T = {3'h1, 3'h7, 3'h3, 3'h5};
  localparam logic [23:0] VDL_T = {3'h4, 3'h5, 3'h7, 3'h6, 3'h2, 3'h3, 3'h1, 3'h0};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic codeEnable = 1'b0;
  dsc_pkg::dsc_coding_type codingSel = dsc_pkg::CODE_NONE;
  logic threeBitSym = 1'b0;
  logic symValid = 1'b0;
  logic [2:0] symData = 3'h0;
  logic stall = 1'b0;
  logic symReady, outValid, outReady;
  logic [2:0] outSym, outStep, outPhase;
  int errTotal = 0;
  int totalChecks = 0;
  logic [8:0] seen [$];

  always #5 clock = ~clock;

  dsc_coder DUT (.clock, .rst, .codeEnable, .codingSel, .threeBitSym, .symValid, .symReady, .symData,
    .outValid, .outReady, .outSym, .outStep, .outPhase);
  dsc_phase_sink sink (.clock, .rst, .stall, .outValid, .outReady);

  // record every accepted output word
  always @(posedge clock) begin
    if (outValid === 1'b1 && outReady === 1'b1) begin
      seen.push_back({outSym, outStep, outPhase});
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [2:0] stepOf(input dsc_pkg::dsc_coding_type s, input logic [2:0] a);
    case (s)
      dsc_pkg::CODE_PI4_OFF: return OFF_T[3 * a[1:0] +: 3];
      dsc_pkg::CODE_PI4_NADC: return NADC_T[3 * a[1:0] +: 3];
      dsc_pkg::CODE_PI4_TFTS: return TFTS_T[3 * a[1:0] +: 3];
      default: return VDL_T[3 * a +: 3];
    endcase
  endfunction : stepOf

  task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
    totalChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic chkCount(input string what, input int exp, input int got);
    totalChecks++;
    if (got != exp) begin
      errTotal++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chkCount

  // hold the symbol until an edge with ready high
  task automatic pushSym(input logic [2:0] a);
    symValid <= 1'b1;
    symData <= a;
    do @(negedge clock); while (symReady !== 1'b1);
    @(posedge clock);
  endtask : pushSym

  task automatic runSeq(input string name, input dsc_pkg::dsc_coding_type sel, input logic three,
    input logic fill, input logic [2:0] syms [$]);
    logic [2:0] a, b, p, g, st, ph;
    int n;
    b = 3'h0;
    p = 3'h0;
    n = 0;
    codingSel <= sel;
    threeBitSym <= three;
    codeEnable <= 1'b0;
    stall <= fill;
    seen.delete();
    repeat (2) @(posedge clock);
    if (!fill) codeEnable <= 1'b1;
    foreach (syms[i]) pushSym(syms[i]);
    symValid <= 1'b0;
    if (fill) begin
      @(negedge clock);
      chk("symReady", 3'h0, {2'h0, symReady});
      @(posedge clock);
      codeEnable <= 1'b1;
    end
    while (seen.size() < syms.size() && n < 400) begin
      @(posedge clock);
      n++;
    end
    chkCount("outCount", syms.size(), seen.size());
    foreach (syms[i]) begin
      a = three ? syms[i] : {1'b0, syms[i][1:0]};
      g = (sel == dsc_pkg::CODE_DIFF_GRAY) ? a ^ (a >> 1) : a;
      if (sel == dsc_pkg::CODE_DIFF || sel == dsc_pkg::CODE_DIFF_GRAY) begin
        b = three ? 3'(g + b) : {1'b0, 2'(g[1:0] + b[1:0])};
        st = three ? g : {g[1:0], 1'b0};
        ph = three ? b : {b[1:0], 1'b0};
        chk("outSym", b, seen[i][8:6]);
      end else if (sel == dsc_pkg::CODE_NONE) begin
        ph = three ? a : {a[1:0], 1'b0};
        st = 3'(ph - p);
        chk("outSym", a, seen[i][8:6]);
      end else begin
        st = stepOf(sel, a);
        ph = 3'(p + st);
        chk("outSym", (sel == dsc_pkg::CODE_VDL) ? ph : a, seen[i][8:6]);
      end
      p = ph;
      chk("outStep", st, seen[i][5:3]);
      chk("outPhase", ph, seen[i][2:0]);
    end
    $display("test %s done", name);
  endtask : runSeq

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic testDiff2;
    runSeq("diff2", dsc_pkg::CODE_DIFF, 1'b0, 1'b0, '{3'h2, 3'h2, 3'h2, 3'h1, 3'h3, 3'h6});
  endtask : testDiff2

  task automatic testGray8;
    runSeq("gray8", dsc_pkg::CODE_DIFF_GRAY, 1'b1, 1'b0, '{3'h3, 3'h7, 3'h5, 3'h6, 3'h1});
  endtask : testGray8

  task automatic testGray2;
    runSeq("gray2", dsc_pkg::CODE_DIFF_GRAY, 1'b0, 1'b0, '{3'h1, 3'h3, 3'h2, 3'h6});
  endtask : testGray2

  task automatic testNone;
    runSeq("none", dsc_pkg::CODE_NONE, 1'b1, 1'b0, '{3'h5, 3'h2, 3'h7, 3'h0});
  endtask : testNone

  task automatic testPi4;
    dsc_pkg::dsc_coding_type m [3] = '{dsc_pkg::CODE_PI4_OFF, dsc_pkg::CODE_PI4_NADC, dsc_pkg::CODE_PI4_TFTS};
    foreach (m[k]) runSeq("pi4", m[k], 1'b0, 1'b0, '{3'h0, 3'h1, 3'h2, 3'h3, 3'h3});
  endtask : testPi4

  task automatic testVdl;
    runSeq("vdl", dsc_pkg::CODE_VDL, 1'b1, 1'b0, '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7});
  endtask : testVdl

  task automatic testFill;
    logic [2:0] q [$];
    for (int i = 0; i < 32; i++) q.push_back(3'(i * 5));
    runSeq("fill", dsc_pkg::CODE_DIFF, 1'b1, 1'b1, q);
  endtask : testFill

  task automatic finishTest;
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finishTest

  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    testDiff2();
    testGray8();
    testGray2();
    testNone();
    testPi4();
    testVdl();
    testFill();
    finishTest();
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge clock);
    errTotal++;
    $display("ERROR watchdog expected done seen hang");
    finishTest();
  end
endmodule : dsc_coder_tb

bind dsc_coder dsc_coder_monitor mon (.clock, .rst, .codeEnable, .codingSel, .threeBitSym, .symValid,
  .symReady, .symData, .outValid, .outReady, .outSym, .outStep, .outPhase);

//--- dv/dsc_phase_sink.sv
// downstream phase mapper model: accepts promptly or every other cycle
`timescale 1ns/1ps
module dsc_phase_sink (
  input wire logic clock,
  input wire logic rst,
  input wire logic stall,
  input wire logic outValid,
  output logic outReady
);
  logic accept_q;
  // toggle acceptance while stalling
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      accept_q <= 1'b0;
    end else begin
      accept_q <= stall ? ~accept_q : 1'b1;
    end
  end
  assign outReady = accept_q;
endmodule : dsc_phase_sink
